// [rtl/arp_dev_end.sv]
/*
 Register bank end: pointer, eight data registers, conversion result and alert flags.
 Assumes a controller on the link that keeps the byte protocol and a converter
 that reports each finished result with a one-cycle conv_done_i pulse.
*/
// Local design decision: the AHB-Lite interface to the registers.
// How it works
// - Power-on reset loads every register default.
// - Eight registers plus pointer; result is read-only.
// - First byte of each write sets pointer.
// - Only three low pointer bits are kept.
// - Pointer resets to zero, the result register.
// - Pointer value selects register per fixed map.
// - Normal mode result read starts a conversion.
// - Result in bits 11:2, others zero.
// - Bit 15 shows flag OR when enabled.
// - Flags active high; status bits 7:2 zero.
// - Result above upper limit sets over flag.
// - Result below lower limit sets under flag.
// - Writing one clears that alert flag.
// - Without hold, over clears below limit minus margin.
// - Without hold, under clears above limit plus margin.
// - With hold, only a one write clears.
// - Configuration bit 4 is alert hold.
// - Configuration bit 3 gates the bit 15 summary.
`timescale 1ns/100ps
`default_nettype none
module arp_dev_end (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    arp_link_if.dev               link,
    input  wire logic             conv_done_i,
    input  wire logic [9:0]       conv_result_i,
    input  wire logic             power_down_i,
    output logic                  conv_start_o,
    output logic [2:0]            cycle_time_o,
    output logic                  alert_o
);
    typedef struct packed {
        logic [2:0] ptr;
        logic       expect_ptr;
        logic       wr_hi_pend;
        logic [7:0] hi_buf;
        logic       rd_lo_next;
        logic [7:0] rd_byte;
        logic       rd_valid;
        logic       res_read;
        logic       conv_start;
        logic [9:0] result;
        logic [1:0] status;
        logic [7:0] cfg;
        logic [9:0] low;
        logic [9:0] high;
        logic [9:0] hyst;
        logic [9:0] lowest;
        logic [9:0] highest;
    } arp_dev_s;

    localparam arp_dev_s RESET_STATE = '{
        ptr: arp_pkg::IDX_RESULT, expect_ptr: 1'b0, wr_hi_pend: 1'b0, hi_buf: 8'h00,
        rd_lo_next: 1'b0, rd_byte: 8'h00, rd_valid: 1'b0, res_read: 1'b0,
        conv_start: 1'b0, result: arp_pkg::RESULT_RESET, status: arp_pkg::STATUS_RESET,
        cfg: arp_pkg::CFG_RESET, low: arp_pkg::LOW_RESET, high: arp_pkg::HIGH_RESET,
        hyst: arp_pkg::HYST_RESET, lowest: arp_pkg::LOWEST_RESET,
        highest: arp_pkg::HIGHEST_RESET};

    arp_dev_s s;
    arp_dev_s next_s;

    function automatic logic [15:0] read_word(input arp_dev_s r);
        logic [15:0] w;
        w = 16'h0000;
        unique case (r.ptr)
            arp_pkg::IDX_RESULT: begin
                w = arp_pkg::place_word(r.result);
                w[arp_pkg::ALERT_SUM_BIT] = r.cfg[arp_pkg::CFG_FLAG_EN] & (|r.status);
            end
            arp_pkg::IDX_STATUS:  w = {14'h0000, r.status};
            arp_pkg::IDX_CONFIG:  w = {8'h00, r.cfg};
            arp_pkg::IDX_LOW:     w = arp_pkg::place_word(r.low);
            arp_pkg::IDX_HIGH:    w = arp_pkg::place_word(r.high);
            arp_pkg::IDX_HYST:    w = arp_pkg::place_word(r.hyst);
            arp_pkg::IDX_LOWEST:  w = arp_pkg::place_word(r.lowest);
            arp_pkg::IDX_HIGHEST: w = arp_pkg::place_word(r.highest);
        endcase
        return w;
    endfunction

    function automatic logic [9:0] take_word(input logic [15:0] w);
        return w[arp_pkg::WORD_MSB:arp_pkg::WORD_LSB];
    endfunction

    always_comb begin
        logic [1:0]  clr;
        logic [15:0] word;
        logic [10:0] over_floor;
        logic [10:0] under_ceil;
        logic        hold;
        logic        over_set;
        logic        under_set;
        logic        over_free;
        logic        under_free;
        clr = 2'h0;
        word = 16'h0000;
        over_floor = 11'h000;
        under_ceil = 11'h000;
        hold = s.cfg[arp_pkg::CFG_HOLD];
        over_set = 1'b0;
        under_set = 1'b0;
        over_free = 1'b0;
        under_free = 1'b0;
        next_s = s;
        next_s.rd_valid = 1'b0;
        next_s.conv_start = 1'b0;
        if (link.frame_start) begin
            next_s.expect_ptr = ~link.frame_read;
            // An unpaired high byte dies here and never joins the next frame.
            next_s.wr_hi_pend = 1'b0;
            next_s.rd_lo_next = 1'b0;
        end
        if (link.wr_valid) begin
            // Upper pointer bits are dropped, so no stray index reaches a missing register.
            if (s.expect_ptr) begin
                next_s.ptr = link.wr_byte[arp_pkg::PTR_W-1:0];
                next_s.expect_ptr = 1'b0;
            end else if (arp_pkg::reg_is_byte(s.ptr)) begin
                if (s.ptr == arp_pkg::IDX_STATUS) begin
                    clr = link.wr_byte[1:0];
                end else begin
                    next_s.cfg = link.wr_byte & arp_pkg::CFG_WMASK;
                end
            end else if (!s.wr_hi_pend) begin
                next_s.hi_buf = link.wr_byte;
                next_s.wr_hi_pend = 1'b1;
            end else begin
                next_s.wr_hi_pend = 1'b0;
                word = {s.hi_buf, link.wr_byte};
                unique case (s.ptr)
                    arp_pkg::IDX_LOW:     next_s.low = take_word(word);
                    arp_pkg::IDX_HIGH:    next_s.high = take_word(word);
                    arp_pkg::IDX_HYST:    next_s.hyst = take_word(word);
                    arp_pkg::IDX_LOWEST:  next_s.lowest = take_word(word);
                    arp_pkg::IDX_HIGHEST: next_s.highest = take_word(word);
                    default:              next_s.hi_buf = s.hi_buf;
                endcase
            end
        end
        if (link.rd_req) begin
            word = read_word(s);
            next_s.rd_valid = 1'b1;
            if (arp_pkg::reg_is_byte(s.ptr) || s.rd_lo_next) begin
                next_s.rd_byte = word[7:0];
            end else begin
                next_s.rd_byte = word[15:8];
            end
            if (!arp_pkg::reg_is_byte(s.ptr)) begin
                next_s.rd_lo_next = ~s.rd_lo_next;
            end
            if (s.ptr == arp_pkg::IDX_RESULT) begin
                next_s.res_read = 1'b1;
            end
        end
        if (link.frame_end) begin
            // Starting at frame end keeps the result stable while its bytes are out.
            next_s.conv_start = s.res_read
                & (s.cfg[arp_pkg::CFG_CYC_MSB:arp_pkg::CFG_CYC_LSB] == 3'h0);
            next_s.res_read = 1'b0;
        end
        next_s.status = s.status & ~clr;
        if (conv_done_i) begin
            next_s.result = conv_result_i;
            if (conv_result_i < s.lowest) begin
                next_s.lowest = conv_result_i;
            end
            if (conv_result_i > s.highest) begin
                next_s.highest = conv_result_i;
            end
            over_floor = {1'b0, conv_result_i} + {1'b0, s.hyst};
            under_ceil = {1'b0, s.low} + {1'b0, s.hyst};
            over_set = conv_result_i > s.high;
            under_set = conv_result_i < s.low;
            over_free = !hold && (over_floor < {1'b0, s.high});
            under_free = !hold && ({1'b0, conv_result_i} > under_ceil);
            // A set in the same cycle as a one-write clear wins, so no event is lost.
            next_s.status[arp_pkg::ST_OVER] = over_set
                | (next_s.status[arp_pkg::ST_OVER] & ~over_free);
            next_s.status[arp_pkg::ST_UNDER] = under_set
                | (next_s.status[arp_pkg::ST_UNDER] & ~under_free);
        end
        if (power_down_i) begin
            next_s = RESET_STATE;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign link.rd_valid = s.rd_valid;
    assign link.rd_byte  = s.rd_byte;
    assign conv_start_o  = s.conv_start;
    assign cycle_time_o  = s.cfg[arp_pkg::CFG_CYC_MSB:arp_pkg::CFG_CYC_LSB];
    assign alert_o       = |s.status;
endmodule // arp_dev_end
`default_nettype wire

// [shared/arp_pkg.sv]
/*
 Shared constants, register map and helpers for the register-pointer ADC block.
 Assumes both link ends and the controller's AHB-Lite map compile against it.
*/
`default_nettype none
package arp_pkg;
    localparam int RES_W = 10;
    localparam int PTR_W = 3;
    localparam logic [2:0] IDX_RESULT  = 3'h0;
    localparam logic [2:0] IDX_STATUS  = 3'h1;
    localparam logic [2:0] IDX_CONFIG  = 3'h2;
    localparam logic [2:0] IDX_LOW     = 3'h3;
    localparam logic [2:0] IDX_HIGH    = 3'h4;
    localparam logic [2:0] IDX_HYST    = 3'h5;
    localparam logic [2:0] IDX_LOWEST  = 3'h6;
    localparam logic [2:0] IDX_HIGHEST = 3'h7;
    localparam int WORD_MSB      = 11;
    localparam int WORD_LSB      = 2;
    localparam int ALERT_SUM_BIT = 15;
    localparam int ST_OVER       = 1;
    localparam int ST_UNDER      = 0;
    localparam int CFG_HOLD      = 4;
    localparam int CFG_FLAG_EN   = 3;
    localparam int CFG_CYC_LSB   = 5;
    localparam int CFG_CYC_MSB   = 7;
    localparam logic [7:0] CFG_WMASK     = 8'hFD;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [1:0] STATUS_RESET  = 2'h0;
    localparam logic [9:0] RESULT_RESET  = 10'h000;
    localparam logic [9:0] LOW_RESET     = 10'h000;
    localparam logic [9:0] HIGH_RESET    = 10'h3FF;
    localparam logic [9:0] HYST_RESET    = 10'h000;
    localparam logic [9:0] LOWEST_RESET  = 10'h3FF;
    localparam logic [9:0] HIGHEST_RESET = 10'h000;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_WDATA  = 8'h04;
    localparam logic [7:0] OFF_RDATA  = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam int CTL_GO      = 0;
    localparam int CTL_READ    = 1;
    localparam int CTL_KEEP    = 2;
    localparam int CTL_IDX_LSB = 4;
    localparam int CTL_IDX_MSB = 6;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    function automatic logic reg_is_byte(input logic [2:0] idx);
        return (idx == IDX_STATUS) || (idx == IDX_CONFIG);
    endfunction

    function automatic logic [15:0] place_word(input logic [9:0] v);
        return {4'h0, v, 2'h0};
    endfunction
endpackage
`default_nettype wire

// [shared/arp_link_if.sv]
/*
 Byte-level link between the register controller and the register bank.
 Assumes one clock for both ends; the bench connects the two modports.
*/
`timescale 1ns/100ps
`default_nettype none
interface arp_link_if;
    logic       frame_start;
    logic       frame_read;
    logic       wr_valid;
    logic [7:0] wr_byte;
    logic       rd_req;
    logic       rd_valid;
    logic [7:0] rd_byte;
    logic       frame_end;

    modport dev (input frame_start, frame_read, wr_valid, wr_byte, rd_req, frame_end,
                 output rd_valid, rd_byte);
    modport ctl (output frame_start, frame_read, wr_valid, wr_byte, rd_req, frame_end,
                 input rd_valid, rd_byte);
endinterface
`default_nettype wire

// [rtl/arp_ctl_end.sv]
/*
 Controller end: takes register orders from software over AHB-Lite and runs
 pointer, write and read frames on the link. Assumes a zero-wait single slave.
*/
`timescale 1ns/100ps
`default_nettype none
module arp_ctl_end (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic [1:0]       hresp_o,
    output logic [31:0]      hrdata_o,
    arp_link_if.ctl          link
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_START = 7'h02,
        ST_PTR   = 7'h04,
        ST_WDAT  = 7'h08,
        ST_RREQ  = 7'h10,
        ST_RWAIT = 7'h20,
        ST_STOP  = 7'h40
    } arp_ctl_e;

    typedef struct packed {
        arp_ctl_e    st;
        logic [2:0]  idx;
        logic        rd;
        logic        rdphase;
        logic [1:0]  cnt;
        logic [7:0]  tx;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        dwr;
        logic [7:0]  daddr;
        logic [31:0] hrdata;
    } arp_ctl_s;

    arp_ctl_s s;
    arp_ctl_s next_s;

    function automatic logic [1:0] byte_count(input logic [2:0] idx);
        return arp_pkg::reg_is_byte(idx) ? 2'h1 : 2'h2;
    endfunction

    always_comb begin
        logic [2:0] new_idx;
        new_idx = s.idx;
        next_s = s;
        next_s.dwr = 1'b0;
        if (hsel_i && hready_i && htrans_i[1]) begin
            next_s.dwr = hwrite_i;
            next_s.daddr = haddr_i[7:0];
            unique case (haddr_i[7:0])
                arp_pkg::OFF_RDATA:  next_s.hrdata = {16'h0000, s.rdata};
                arp_pkg::OFF_STATUS: next_s.hrdata = {31'h00000000, s.st != ST_IDLE};
                arp_pkg::OFF_WDATA:  next_s.hrdata = {16'h0000, s.wdata};
                default:             next_s.hrdata = 32'h00000000;
            endcase
        end
        if (s.dwr && s.daddr == arp_pkg::OFF_WDATA) begin
            next_s.wdata = hwdata_i[15:0];
        end
        unique case (s.st)
            ST_IDLE: begin
                // Orders that arrive while a frame runs are dropped, not queued.
                if (s.dwr && s.daddr == arp_pkg::OFF_CTRL && hwdata_i[arp_pkg::CTL_GO]) begin
                    if (!hwdata_i[arp_pkg::CTL_KEEP]) begin
                        new_idx = hwdata_i[arp_pkg::CTL_IDX_MSB:arp_pkg::CTL_IDX_LSB];
                    end
                    next_s.idx = new_idx;
                    next_s.rd = hwdata_i[arp_pkg::CTL_READ];
                    next_s.rdphase = hwdata_i[arp_pkg::CTL_READ]
                        & hwdata_i[arp_pkg::CTL_KEEP];
                    next_s.cnt = byte_count(new_idx);
                    next_s.tx = {5'h00, new_idx};
                    next_s.rdata = 16'h0000;
                    next_s.st = ST_START;
                end
            end
            ST_START: next_s.st = s.rdphase ? ST_RREQ : ST_PTR;
            ST_PTR: begin
                next_s.tx = (s.cnt == 2'h2) ? s.wdata[15:8] : s.wdata[7:0];
                next_s.st = s.rd ? ST_STOP : ST_WDAT;
            end
            ST_WDAT: begin
                next_s.tx = s.wdata[7:0];
                next_s.cnt = s.cnt - 2'h1;
                next_s.st = (s.cnt == 2'h1) ? ST_STOP : ST_WDAT;
            end
            ST_RREQ: next_s.st = ST_RWAIT;
            ST_RWAIT: begin
                if (link.rd_valid) begin
                    next_s.rdata = {s.rdata[7:0], link.rd_byte};
                    next_s.cnt = s.cnt - 2'h1;
                    next_s.st = (s.cnt == 2'h1) ? ST_STOP : ST_RREQ;
                end
            end
            ST_STOP: begin
                if (s.rd && !s.rdphase) begin
                    next_s.rdphase = 1'b1;
                    next_s.st = ST_START;
                end else begin
                    next_s.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '{st: ST_IDLE, idx: arp_pkg::IDX_RESULT, rd: 1'b0, rdphase: 1'b0,
                   cnt: 2'h0, tx: 8'h00, wdata: 16'h0000, rdata: 16'h0000, dwr: 1'b0,
                   daddr: 8'h00, hrdata: 32'h00000000};
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout_o      = 1'b1;
    assign hresp_o          = arp_pkg::HRESP_OKAY;
    assign hrdata_o         = s.hrdata;
    assign link.frame_start = s.st == ST_START;
    assign link.frame_read  = s.rdphase;
    assign link.wr_valid    = (s.st == ST_PTR) || (s.st == ST_WDAT);
    assign link.wr_byte     = s.tx;
    assign link.rd_req      = s.st == ST_RREQ;
    assign link.frame_end   = s.st == ST_STOP;
endmodule // arp_ctl_end
`default_nettype wire

// [testbench/arp_link_props.sv]
/*
 Checker for the byte link between the controller end and the register end.
 Assumes one clock, an active-low asynchronous reset and instantiation beside the link.
*/
`timescale 1ns/100ps
`default_nettype none
module arp_link_props (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       frame_start,
    input  wire logic       frame_read,
    input  wire logic       wr_valid,
    input  wire logic [7:0] wr_byte,
    input  wire logic       rd_req,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_byte,
    input  wire logic       frame_end
);
    logic [2:0] ptr;
    logic       want;
    logic       hi;

    // A shadow of the pointer lets read bytes be judged by the register they came from.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr  <= 3'h0;
            want <= 1'b0;
            hi   <= 1'b1;
        end else begin
            if (frame_start) begin
                want <= !frame_read;
                hi   <= 1'b1;
            end else begin
                if (wr_valid) begin
                    want <= 1'b0;
                end
                if (rd_valid) begin
                    hi <= !hi;
                end
            end
            if (wr_valid && want) begin
                ptr <= wr_byte[2:0];
            end
        end
    end

    default clocking dc @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_RD_ANSWER: assert property (rd_req |=> rd_valid)
        else $error("read byte not answered one cycle after its request");
    AST_RD_CAUSE: assert property (rd_valid |-> $past(rd_req))
        else $error("read byte returned without a request");
    AST_START_PULSE: assert property (frame_start |=> !frame_start)
        else $error("frame start longer than one cycle");
    AST_PTR_BYTE: assert property (frame_start && !frame_read |=>
        wr_valid && wr_byte[7:3] == 5'h0)
        else $error("write frame does not open with a clean pointer byte");
    AST_RD_FRAME: assert property (frame_start && frame_read |=> rd_req && !wr_valid)
        else $error("read frame does not begin with a byte request");
    AST_STROBE_EXCL: assert property (wr_valid |-> !(rd_req || frame_start || frame_end))
        else $error("write byte overlaps another link strobe");
    AST_RES_HI: assert property (rd_valid && ptr == 3'h0 && hi |-> rd_byte[6:4] == 3'h0)
        else $error("result high byte has reserved bits set");
    AST_RES_LO: assert property (rd_valid && ptr == 3'h0 && !hi |-> rd_byte[1:0] == 2'h0)
        else $error("result low byte has reserved bits set");
    AST_STAT_ZERO: assert property (rd_valid && ptr == 3'h1 |-> rd_byte[7:2] == 6'h00)
        else $error("status byte has reserved bits set");

    COV_WRITE: cover property (frame_start && !frame_read);
    COV_RES_RD: cover property (rd_valid && ptr == 3'h0 && hi);
    COV_STAT_RD: cover property (rd_valid && ptr == 3'h1 && rd_byte != 8'h00);
endmodule // arp_link_props
`default_nettype wire

// [testbench/tb_adc_register_pointer_alert_status.sv]
/*
 Testbench: both ends joined by the link, software side driven over AHB-Lite.
 Assumes the package and the link interface are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_adc_register_pointer_alert_status;
    logic        sys_clk_i = 1'b0;
    logic        resetn_i;
    logic        hsel_i;
    logic [31:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [2:0]  hsize_i;
    logic [31:0] hwdata_i;
    logic        hreadyout_o;
    logic [31:0] hrdata_o;
    logic        conv_done_i;
    logic [9:0]  conv_result_i;
    logic        power_down_i;
    logic        conv_start_o;
    logic [2:0]  cycle_time_o;
    logic        alert_o;
    int          err_total = 0;
    int          checks = 0;
    int          starts = 0;
    int          cycles = 0;
    logic [15:0] dflt [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0FFC, 16'h0000, 16'h0FFC, 16'h0000};

    arp_link_if link_bus ();
    arp_dev_end u_arp_dev_end (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .link(link_bus.dev),
        .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .power_down_i(power_down_i),
        .conv_start_o(conv_start_o), .cycle_time_o(cycle_time_o), .alert_o(alert_o));
    arp_ctl_end u_arp_ctl_end (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(),
        .hrdata_o(hrdata_o), .link(link_bus.ctl));
    arp_link_props u_arp_link_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .frame_start(link_bus.frame_start), .frame_read(link_bus.frame_read),
        .wr_valid(link_bus.wr_valid), .wr_byte(link_bus.wr_byte), .rd_req(link_bus.rd_req),
        .rd_valid(link_bus.rd_valid), .rd_byte(link_bus.rd_byte), .frame_end(link_bus.frame_end));

    always #25 sys_clk_i = ~sys_clk_i;

    // The ceiling is several times the expected run, so only a hang reaches it.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (conv_start_o === 1'b1) begin
            starts++;
        end
        if (cycles == 20000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("TB: checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge sys_clk_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= {24'h0, a};
        hwrite_i <= wr;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
    endtask

    // Busy is polled rather than timed, so the link speed is free to change.
    task automatic op(input logic [2:0] idx, input logic [3:0] cmd, output logic [15:0] v);
        logic [31:0] q;
        ahb(1'b1, arp_pkg::OFF_CTRL, {25'h0, idx, cmd}, q);
        do ahb(1'b0, arp_pkg::OFF_STATUS, 32'h0, q); while (q[0] !== 1'b0);
        ahb(1'b0, arp_pkg::OFF_RDATA, 32'h0, q);
        v = q[15:0];
    endtask

    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        logic [31:0] q;
        logic [15:0] v;
        ahb(1'b1, arp_pkg::OFF_WDATA, {16'h0, d}, q);
        op(idx, 4'h1, v);
    endtask

    task automatic rd_chk(input logic [2:0] idx, input logic keep, input logic [15:0] exp);
        logic [15:0] v;
        op(idx, keep ? 4'h7 : 4'h3, v);
        chk(v, exp);
    endtask

    task automatic step(input logic [9:0] v, input logic [7:0] st, input logic [15:0] res);
        @(posedge sys_clk_i);
        conv_done_i   <= 1'b1;
        conv_result_i <= v;
        @(posedge sys_clk_i);
        conv_done_i <= 1'b0;
        rd_chk(3'h1, 1'b0, {8'h00, st});
        rd_chk(3'h0, 1'b0, res);
        chk({15'h0, alert_o}, {15'h0, |st});
    endtask

    initial begin
        int s;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'h0;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        conv_done_i = 1'b0;
        conv_result_i = 10'h000;
        power_down_i = 1'b0;
        resetn_i = 1'b0;
        repeat (16) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd_chk(3'h5, 1'b1, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            rd_chk(i[2:0], 1'b0, dflt[i]);
        end
        s = starts;
        wr(3'h0, 16'h1234);
        rd_chk(3'h0, 1'b0, 16'h0000);
        chk(16'(starts - s), 16'h0001);
        wr(3'h3, 16'h0400);
        wr(3'h4, 16'h0800);
        wr(3'h5, 16'h0040);
        wr(3'h2, 16'h0008);
        step(10'h250, 8'h02, 16'h8940);
        step(10'h1F5, 8'h02, 16'h87D4);
        step(10'h1EF, 8'h00, 16'h07BC);
        step(10'h0FF, 8'h01, 16'h83FC);
        step(10'h110, 8'h01, 16'h8440);
        step(10'h111, 8'h00, 16'h0444);
        step(10'h250, 8'h02, 16'h8940);
        wr(3'h1, 16'h0002);
        rd_chk(3'h1, 1'b0, 16'h0000);
        wr(3'h2, 16'h0018);
        step(10'h300, 8'h02, 16'h8C00);
        step(10'h180, 8'h02, 16'h8600);
        step(10'h000, 8'h03, 16'h8000);
        wr(3'h1, 16'h0002);
        rd_chk(3'h1, 1'b0, 16'h0001);
        wr(3'h1, 16'h0001);
        rd_chk(3'h1, 1'b0, 16'h0000);
        wr(3'h2, 16'h0010);
        step(10'h300, 8'h02, 16'h0C00);
        wr(3'h2, 16'h00E0);
        chk({13'h0000, cycle_time_o}, 16'h0007);
        s = starts;
        rd_chk(3'h0, 1'b0, 16'h0C00);
        chk(16'(starts - s), 16'h0000);
        rd_chk(3'h4, 1'b0, 16'h0800);
        rd_chk(3'h0, 1'b1, 16'h0800);
        @(posedge sys_clk_i);
        power_down_i <= 1'b1;
        @(posedge sys_clk_i);
        power_down_i <= 1'b0;
        rd_chk(3'h2, 1'b0, 16'h0000);
        rd_chk(3'h4, 1'b0, 16'h0FFC);
        rd_chk(3'h1, 1'b0, 16'h0000);
        rd_chk(3'h6, 1'b0, 16'h0FFC);
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd_chk(3'h5, 1'b1, 16'h0000);
        complete_run();
    end
endmodule // tb_adc_register_pointer_alert_status
`default_nettype wire
